/* design/sei_pkg.sv */
// Purpose: shared constants and types for the serial eeprom command block
// Assumes: system clock of 5 ns; all pins sampled on that clock
// Notes:   byte array is two banks of 256 bytes; x16 word = {bank0,bank1}
package sei_pkg;

	// system clock period
	localparam int CLK_NS = 5;

	// self-timed programming times, in ns
	localparam int T_WORD_SLOW_NS = 6_000_000;
	localparam int T_WORD_FAST_NS = 2_000_000;
	localparam int T_ERASE_ALL_NS = 6_000_000;
	localparam int T_WRITE_ALL_NS = 15_000_000;
	// least chip select low time before status shows, in ns
	localparam int T_CSL_NS = 250;

	// longest times round down, least time rounds up
	localparam int WORD_SLOW_CYC = T_WORD_SLOW_NS / CLK_NS;
	localparam int WORD_FAST_CYC = T_WORD_FAST_NS / CLK_NS;
	localparam int ERASE_ALL_CYC = T_ERASE_ALL_NS / CLK_NS;
	localparam int WRITE_ALL_CYC = T_WRITE_ALL_NS / CLK_NS;
	localparam int CSL_CYC       = (T_CSL_NS + CLK_NS - 1) / CLK_NS;

	// serial clocks per instruction, start bit included
	localparam logic [4:0] CLKS_SHORT16 = 5'h0B;
	localparam logic [4:0] CLKS_LONG16  = 5'h1B;
	localparam logic [4:0] CLKS_SHORT8  = 5'h0C;
	localparam logic [4:0] CLKS_LONG8   = 5'h14;

	// opcodes and special-command qualifiers
	localparam logic [1:0] OPC_SPECIAL = 2'h0;
	localparam logic [1:0] OPC_WRITE   = 2'h1;
	localparam logic [1:0] OPC_READ    = 2'h2;
	localparam logic [1:0] OPC_ERASE   = 2'h3;
	localparam logic [1:0] SUB_DISABLE = 2'h0;
	localparam logic [1:0] SUB_WR_ALL  = 2'h1;
	localparam logic [1:0] SUB_ER_ALL  = 2'h2;
	localparam logic [1:0] SUB_ENABLE  = 2'h3;

	// value of an erased byte
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	typedef logic [21:0] sei_tmr_t;
	typedef logic [5:0]  sei_csl_t;

	// decoder states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_CMD   = 5'h02,
		ST_DATA  = 5'h04,
		ST_RDOUT = 5'h08,
		ST_DONE  = 5'h10
	} sei_st_t;

	// programming operations
	typedef enum logic [2:0] {
		OPK_NONE  = 3'h0,
		OPK_ERASE = 3'h1,
		OPK_WRITE = 3'h2,
		OPK_ER_ALL = 3'h3,
		OPK_WR_ALL = 3'h4
	} sei_op_t;

	// raw pin levels
	typedef struct packed {
		logic cs;
		logic clk;
		logic di;
		logic wide;
		logic fast;
	} sei_pins_t;

	// synchronised levels and edges
	typedef struct packed {
		logic cs;
		logic di;
		logic wide;
		logic fast;
		logic clk_rise;
		logic cs_fall;
		logic cs_rise;
	} sei_link_t;

	// synchroniser state
	typedef struct packed {
		sei_pins_t s1;
		sei_pins_t s2;
		logic      clk3;
		logic      cs3;
	} sei_sync_t;

	localparam sei_sync_t SYNC_RESET = '0;

	// command block state
	typedef struct packed {
		sei_st_t    st;
		logic [4:0] cnt;
		logic [25:0] sr;
		logic       prog_en;
		logic       busy;
		sei_op_t    cur;
		sei_op_t    dop;
		sei_tmr_t   tmr;
		logic       sweeping;
		logic [7:0] sweep;
		sei_op_t    pend;
		logic [8:0] paddr;
		logic [15:0] pdata;
		logic [8:0] raddr;
		logic [15:0] rsh;
		logic [4:0] rcnt;
		logic       rld;
		logic       do_q;
		logic       oe_q;
		logic       shw;
		logic       arm;
		logic       start_seen;
		sei_csl_t   csl;
		logic       csl_ok;
	} sei_state_t;

	localparam sei_state_t STATE_RESET = '{st: ST_IDLE, cur: OPK_NONE, dop: OPK_NONE,
		pend: OPK_NONE, default: '0};

endpackage

/* design/sei_sync.sv */
// Purpose: bring the serial pins into the system clock and find their edges
// Assumes: pins are asynchronous to MCLK
// Notes:   edges come from the second and third stages only
`timescale 1ns/1ps
module sei_sync
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_b,
	// pins in, clean levels out
	input  wire sei_pkg::sei_pins_t pins,
	output sei_pkg::sei_link_t      link
);

	sei_pkg::sei_sync_t q;   // registered state
	sei_pkg::sei_sync_t d;   // next state

	// two stages per pin, plus a delay stage for edges
	always_comb
	begin
		d      = q;
		d.s1   = pins;
		d.s2   = q.s1;
		d.clk3 = q.s2.clk;
		d.cs3  = q.s2.cs;
	end

	// state register
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			q <= sei_pkg::SYNC_RESET;
		else
			q <= d;
	end

	// levels and one-cycle edge pulses
	assign link.cs       = q.s2.cs;
	assign link.di       = q.s2.di;
	assign link.wide     = q.s2.wide;
	assign link.fast     = q.s2.fast;
	assign link.clk_rise = q.s2.clk & ~q.clk3;
	assign link.cs_fall  = ~q.s2.cs & q.cs3;
	assign link.cs_rise  = q.s2.cs & ~q.cs3;

endmodule

/* design/sei_top.sv */
// Purpose: command decoder and self-timed control of a 4-Kbit serial eeprom
// Assumes: serial pins sampled on MCLK; serial clock far slower than MCLK
// Notes:   all long cycle counts are parameters so a bench can shorten them
`timescale 1ns/1ps
module sei_top
#(
	parameter int WORD_SLOW_CYC = sei_pkg::WORD_SLOW_CYC,
	parameter int WORD_FAST_CYC = sei_pkg::WORD_FAST_CYC,
	parameter int ERASE_ALL_CYC = sei_pkg::ERASE_ALL_CYC,
	parameter int WRITE_ALL_CYC = sei_pkg::WRITE_ALL_CYC
)
(
	// clock and reset
	input  wire logic MCLK,
	input  wire logic RST_B,
	// serial pins
	input  wire logic SER_CS,
	input  wire logic SER_CLK,
	input  wire logic SER_DI,
	output logic      SER_DO,
	output logic      SER_DO_OE,
	// configuration straps
	input  wire logic WORD_WIDTH_SELECT,
	input  wire logic FAST_START,
	// status
	output logic      PROG_ENABLED,
	output logic      PROG_BUSY
);

	sei_pkg::sei_pins_t  pins;        // raw pins
	sei_pkg::sei_link_t  lk;          // synchronised pins
	sei_pkg::sei_state_t q;           // registered state
	sei_pkg::sei_state_t d;           // next state
	logic [1:0]          we;          // bank write enables
	logic [7:0]          wrow;        // write row
	logic [1:0][7:0]     wbyte;       // write bytes per bank
	logic [7:0]          rrow;        // read row
	logic [1:0][7:0]     rbyte;       // read bytes per bank
	logic [15:0]         rword;       // word being read, left aligned
	logic [25:0]         nsr;         // shift register with new bit
	logic [4:0]          cmd_n;       // bits after start for command
	logic [4:0]          data_n;      // data bits of the organisation
	logic [1:0]          opc;         // decoded opcode
	logic [1:0]          sub;         // special qualifier
	logic [8:0]          addr;        // decoded address
	sei_pkg::sei_op_t    issue;       // operation complete this edge
	logic                c_pdis;      // disable executes this edge

	// pin synchroniser and edge finder
	assign pins = '{cs: SER_CS, clk: SER_CLK, di: SER_DI,
		wide: WORD_WIDTH_SELECT, fast: FAST_START};

	sei_sync u_sync
	(
		.clk   (MCLK),
		.rst_b (RST_B),
		.pins  (pins),
		.link  (lk)
	);

	// two byte banks; x8 address bit 0 picks the bank
	for (genvar b = 0; b < 2; b++)
	begin : g_bank
		logic [7:0] arr [256];   // bank storage

		// write port
		always_ff @(posedge MCLK)
		begin
			if (we[b])
				arr[wrow] <= wbyte[b];
		end

		// read port
		assign rbyte[b] = arr[rrow];
	end

	// next-state logic
	always_comb
	begin
		d      = q;
		we     = 2'h0;
		wrow   = 8'h00;
		wbyte  = '0;
		c_pdis = 1'b0;
		issue  = sei_pkg::OPK_NONE;
		nsr    = {q.sr[24:0], lk.di};
		// field layout by organisation
		cmd_n  = (lk.wide ? sei_pkg::CLKS_SHORT16 : sei_pkg::CLKS_SHORT8) - 5'h01;
		data_n = lk.wide ? (sei_pkg::CLKS_LONG16 - sei_pkg::CLKS_SHORT16)
			: (sei_pkg::CLKS_LONG8 - sei_pkg::CLKS_SHORT8);
		opc    = lk.wide ? nsr[9:8] : nsr[10:9];
		sub    = lk.wide ? nsr[7:6] : nsr[8:7];
		addr   = lk.wide ? {1'b0, nsr[7:0]} : nsr[8:0];
		rrow   = lk.wide ? q.raddr[7:0] : q.raddr[8:1];
		rword  = lk.wide ? {rbyte[0], rbyte[1]}
			: {(q.raddr[0] ? rbyte[1] : rbyte[0]), 8'h00};

		// programming cycle timer
		if (q.busy)
		begin
			if (q.tmr == '0)
				d.busy = 1'b0;
			else
				d.tmr = q.tmr - sei_pkg::sei_tmr_t'(1);
		end

		// whole-array sweep, one row per cycle
		if (q.sweeping)
		begin
			we   = 2'h3;
			wrow = q.sweep;
			if (q.cur == sei_pkg::OPK_ER_ALL)
				wbyte = {2{sei_pkg::ERASED_BYTE}};
			else if (lk.wide)
				wbyte = {q.pdata[7:0], q.pdata[15:8]};
			else
				wbyte = {2{q.pdata[7:0]}};
			d.sweep = q.sweep + 8'h01;
			if (q.sweep == 8'hFF)
				d.sweeping = 1'b0;
		end

		// word for a read, fetched one cycle after the address
		if (q.rld)
		begin
			d.rsh = rword;
			d.rld = 1'b0;
		end

		// select low: hold decoder in reset, float data-out
		if (!lk.cs)
		begin
			d.st   = sei_pkg::ST_IDLE;
			d.cnt  = 5'h00;
			d.oe_q = 1'b0;
			d.shw  = 1'b0;
			if (q.csl != '1)
				d.csl = q.csl + sei_pkg::sei_csl_t'(1);
			d.start_seen = 1'b0;
			if (lk.cs_fall && q.start_seen)
				d.arm = 1'b0;
		end
		else
		begin
			// standby left on select high; low time judged here
			if (lk.cs_rise)
				d.csl_ok = (q.csl >= sei_pkg::sei_csl_t'(sei_pkg::CSL_CYC));
			d.csl = '0;
		end

		// serial clock rising edge while selected
		if (lk.cs && lk.clk_rise)
		begin
			unique case (q.st)
				sei_pkg::ST_IDLE:
				begin
					// start condition
					if (lk.di)
					begin
						d.st      = sei_pkg::ST_CMD;
						d.cnt     = 5'h00;
						d.start_seen = 1'b1;
					end
				end
				sei_pkg::ST_CMD:
				begin
					// opcode and address bits
					d.sr  = nsr;
					d.cnt = q.cnt + 5'h01;
					if (q.cnt + 5'h01 == cmd_n)
					begin
						d.cnt   = 5'h00;
						d.paddr = addr;
						d.st    = sei_pkg::ST_DONE;
						unique case (opc)
							sei_pkg::OPC_READ:
							begin
								// dummy zero first, then the word
								d.raddr = addr;
								d.rld   = 1'b1;
								d.rcnt  = 5'h00;
								d.st    = sei_pkg::ST_RDOUT;
								d.oe_q  = 1'b1;
								d.do_q  = 1'b0;
							end
							sei_pkg::OPC_WRITE:
							begin
								d.dop = sei_pkg::OPK_WRITE;
								d.st  = sei_pkg::ST_DATA;
							end
							sei_pkg::OPC_ERASE:
								issue = sei_pkg::OPK_ERASE;
							sei_pkg::OPC_SPECIAL:
							begin
								unique case (sub)
									sei_pkg::SUB_ER_ALL:
										issue = sei_pkg::OPK_ER_ALL;
									sei_pkg::SUB_WR_ALL:
									begin
										d.dop = sei_pkg::OPK_WR_ALL;
										d.st  = sei_pkg::ST_DATA;
									end
									sei_pkg::SUB_ENABLE:
										d.prog_en = 1'b1;
									sei_pkg::SUB_DISABLE:
									begin
										d.prog_en = 1'b0;
										c_pdis    = 1'b1;
									end
								endcase
							end
						endcase
					end
				end
				sei_pkg::ST_DATA:
				begin
					// write data bits
					d.sr  = nsr;
					d.cnt = q.cnt + 5'h01;
					if (q.cnt + 5'h01 == data_n)
					begin
						d.pdata = lk.wide ? nsr[15:0] : {8'h00, nsr[7:0]};
						issue   = q.dop;
						d.st    = sei_pkg::ST_DONE;
					end
				end
				sei_pkg::ST_RDOUT:
				begin
					// shift out, wrap into the next word
					d.do_q = q.rsh[15];
					d.rsh  = {q.rsh[14:0], 1'b0};
					d.rcnt = q.rcnt + 5'h01;
					if (q.rcnt + 5'h01 == data_n)
					begin
						d.rcnt  = 5'h00;
						d.raddr = q.raddr + 9'h001;
						d.rld   = 1'b1;
					end
				end
				sei_pkg::ST_DONE:
				begin
					// wait for select low
				end
				default:
					d.st = sei_pkg::ST_IDLE;
			endcase
		end

		// only an enabled device queues a programming cycle
		if (issue != sei_pkg::OPK_NONE && q.prog_en)
			d.pend = issue;

		// begin the cycle at select fall, or at once on fast parts
		if (q.pend != sei_pkg::OPK_NONE)
		begin
			if (!q.busy && (lk.fast || lk.cs_fall))
			begin
				d.busy    = 1'b1;
				d.cur     = q.pend;
				d.arm     = 1'b1;
				d.start_seen = 1'b0;
				d.csl_ok  = 1'b0;
				unique case (q.pend)
					sei_pkg::OPK_ER_ALL:
						d.tmr = sei_pkg::sei_tmr_t'(ERASE_ALL_CYC - 1);
					sei_pkg::OPK_WR_ALL:
						d.tmr = sei_pkg::sei_tmr_t'(WRITE_ALL_CYC - 1);
					default:
						d.tmr = lk.fast ? sei_pkg::sei_tmr_t'(WORD_FAST_CYC - 1)
							: sei_pkg::sei_tmr_t'(WORD_SLOW_CYC - 1);
				endcase
				if (q.pend == sei_pkg::OPK_ER_ALL || q.pend == sei_pkg::OPK_WR_ALL)
				begin
					d.sweeping = 1'b1;
					d.sweep    = 8'h00;
				end
				else
				begin
					// single word: auto-erase and program in one write
					if (lk.wide)
					begin
						we   = 2'h3;
						wrow = q.paddr[7:0];
					end
					else
					begin
						we   = q.paddr[0] ? 2'h2 : 2'h1;
						wrow = q.paddr[8:1];
					end
					if (q.pend == sei_pkg::OPK_ERASE)
						wbyte = {2{sei_pkg::ERASED_BYTE}};
					else if (lk.wide)
						wbyte = {q.pdata[7:0], q.pdata[15:8]};
					else
						wbyte = {2{q.pdata[7:0]}};
				end
			end
			if (lk.fast || lk.cs_fall || q.busy)
				d.pend = sei_pkg::OPK_NONE;
		end

		// ready/busy shown on data-out
		if (lk.cs && d.arm && d.csl_ok && d.st != sei_pkg::ST_RDOUT)
		begin
			d.shw  = 1'b1;
			d.oe_q = 1'b1;
			d.do_q = !q.busy;
		end
		else
			d.shw = 1'b0;
		if (!lk.cs || (d.st != sei_pkg::ST_RDOUT && !d.shw))
			d.oe_q = 1'b0;
	end

	// state register
	always_ff @(posedge MCLK or negedge RST_B)
	begin
		if (!RST_B)
			q <= sei_pkg::STATE_RESET;
		else
			q <= d;
	end

	// outputs straight from flip-flops
	assign SER_DO       = q.do_q;
	assign SER_DO_OE    = q.oe_q;
	assign PROG_ENABLED = q.prog_en;
	assign PROG_BUSY    = q.busy;

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);

	start_detect_a : assert property (
		q.st == sei_pkg::ST_IDLE && lk.cs && lk.clk_rise && lk.di
		|=> q.st == sei_pkg::ST_CMD)
		else $error("start condition not taken");
	idle_quiet_a : assert property (
		q.st == sei_pkg::ST_IDLE && !(lk.cs && lk.clk_rise && lk.di)
		|=> q.st == sei_pkg::ST_IDLE)
		else $error("decoder left idle without start");
	do_float_a : assert property (
		$fell(lk.cs) |=> !SER_DO_OE [*2])
		else $error("data-out driven after select fell");
	status_level_a : assert property (
		q.shw |-> SER_DO_OE && SER_DO == !$past(q.busy))
		else $error("status level wrong");
	read_dummy_a : assert property (
		$rose(q.st == sei_pkg::ST_RDOUT) |-> SER_DO_OE && !SER_DO)
		else $error("no dummy zero before read data");
	disabled_prog_a : assert property (
		$rose(q.busy) |-> $past(q.prog_en))
		else $error("cycle started while disabled");
	enable_hold_a : assert property (
		$fell(q.prog_en) |-> $past(c_pdis))
		else $error("enable lost without disable");
	fill_time_a : assert property (
		$rose(q.busy) && q.cur == sei_pkg::OPK_WR_ALL
		|-> q.tmr == sei_pkg::sei_tmr_t'(WRITE_ALL_CYC - 1))
		else $error("write-all time wrong");
	word_time_a : assert property (
		$rose(q.busy) && (q.cur == sei_pkg::OPK_WRITE || q.cur == sei_pkg::OPK_ERASE)
		|-> q.tmr == ($past(lk.fast) ? sei_pkg::sei_tmr_t'(WORD_FAST_CYC - 1)
			: sei_pkg::sei_tmr_t'(WORD_SLOW_CYC - 1)))
		else $error("word cycle time wrong");
	fast_start_a : assert property (
		q.pend != sei_pkg::OPK_NONE && lk.fast && !q.busy |=> q.busy)
		else $error("fast start missed");
	cycle_survive_a : assert property (
		q.busy && !lk.cs && q.tmr != '0 |=> q.busy && q.st == sei_pkg::ST_IDLE)
		else $error("select low disturbed cycle");

endmodule

/* sim/sei_host.sv */
// Purpose: host model driving the serial pins of the eeprom block
// Assumes: select changes after a falling mclk edge; serial clock period 64 ns
// Notes:   serial clock idles low and runs only inside frames
`timescale 1ns/1ps
module sei_host
(
	// system clock
	input  logic mclk,
	// serial pins
	output logic ser_cs,
	output logic ser_clk,
	output logic ser_di,
	input  logic ser_do
);
	logic [31:0] rx; // bits seen in the last noted transfer
	event        got; // fires when rx holds a result

	// pins idle low
	initial
	begin
		ser_cs = 1'b0;
		ser_clk = 1'b0;
		ser_di = 1'b0;
		rx = '0;
	end

	// wait on falling system clock edges
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// select while clock and data are low, so no false start
	task automatic sel();
		ser_di = 1'b0;
		ser_cs = 1'b1;
		tick(3);
	endtask

	// deselect and stay low past the least low time
	task automatic desel();
		ser_cs = 1'b0;
		ser_di = 1'b0;
		tick(55);
	endtask

	// shift n bits msb first, 64 ns per bit; sample data-out just before each next rise
	task automatic xfer(input int n, input logic [31:0] w, input bit note);
		logic [31:0] r;
		r = '0;
		for (int i = n - 1; i >= 0; i--)
		begin
			ser_di = w[i];
			#16;
			ser_clk = 1'b1;
			#32;
			ser_clk = 1'b0;
			#16;
			r = {r[30:0], ser_do};
		end
		ser_di = 1'b0;
		// back onto a falling mclk edge for the caller
		tick(1);
		if (note)
		begin
			rx = r;
			->got;
		end
	endtask
endmodule

/* sim/tb_top.sv */
// Purpose: self-checking bench for the serial eeprom command block
// Assumes: long cycle counts shortened through the top parameters
// Notes:   read data is checked by a watcher against a queue of notes
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	localparam int P_WS = 700; // slow word cycle
	localparam int P_WF = 600; // fast word cycle
	localparam int P_EA = 800; // erase-all cycle
	localparam int P_WA = 900; // write-all cycle

	typedef struct {logic [31:0] m; logic [31:0] v;} sei_note_t;

	logic        mclk, rst_b, cs, sclk, di, dout, oe, wide, fast, en, busy;
	logic [31:0] seed; // lfsr state
	logic [15:0] d, d2; // write data
	logic [8:0]  a; // current address
	int          err_total, checks_done, bcnt, blen;
	sei_note_t   q[$]; // expected read results
	wire         do_pin; // data-out as the host sees it

	assign do_pin = oe ? dout : 1'bz;

	sei_top #(.WORD_SLOW_CYC(P_WS), .WORD_FAST_CYC(P_WF), .ERASE_ALL_CYC(P_EA),
		.WRITE_ALL_CYC(P_WA)) dut (.MCLK(mclk), .RST_B(rst_b), .SER_CS(cs),
		.SER_CLK(sclk), .SER_DI(di), .SER_DO(dout), .SER_DO_OE(oe),
		.WORD_WIDTH_SELECT(wide), .FAST_START(fast), .PROG_ENABLED(en),
		.PROG_BUSY(busy));
	sei_host host (.mclk(mclk), .ser_cs(cs), .ser_clk(sclk), .ser_di(di), .ser_do(do_pin));

	always #2.5 mclk = ~mclk;

	// length of the last busy pulse
	always @(posedge mclk)
	begin
		if (busy === 1'b1)
			bcnt <= bcnt + 1;
		else if (bcnt != 0)
		begin
			blen <= bcnt;
			bcnt <= 0;
		end
	end

	// compare each read result with the oldest note
	always @(host.got)
	begin
		if (q.size() == 0)
		begin
			err_total++;
			$display("CHECK FAILED read data exp none got %0h", host.rx);
		end
		else
		begin
			`CHK("read data", q[0].v, host.rx & q[0].m)
			void'(q.pop_front());
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// special command frame for either width
	function automatic logic [31:0] sp(input logic w, input logic [1:0] s);
		return w ? {21'h0, 1'b1, sei_pkg::OPC_SPECIAL, s, 6'h0}
			: {20'h0, 1'b1, sei_pkg::OPC_SPECIAL, s, 7'h0};
	endfunction

	task automatic final_report();
		if (err_total == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// wait out a busy cycle, bounded
	task automatic settle();
		int t;
		t = 0;
		while (busy !== 1'b0 && t < 3000)
		begin
			@(negedge mclk);
			t++;
		end
		`CHK("busy end", 1'b0, busy)
		repeat (4) @(negedge mclk);
	endtask

	// frame with leading idle clocks; optional status poll
	task automatic prog(input int n, input logic [31:0] w, input int cyc, input bit st);
		blen = 0;
		host.sel();
		host.xfer(3, 32'h0, 0);
		host.xfer(n, w, 0);
		`CHK("busy at last clock", fast && cyc != 0, busy)
		host.desel();
		`CHK("busy after select low", cyc != 0, busy)
		if (st)
		begin
			host.sel();
			host.tick(8);
			`CHK("status while busy", 2'b10, {oe, dout})
		end
		settle();
		`CHK("cycle length", 1'b1, cyc == 0 ? blen == 0 : blen >= cyc - 4 && blen <= cyc + 4)
		if (st)
		begin
			`CHK("status when ready", 2'b11, {oe, dout})
			host.xfer(1, 32'h1, 0);
			host.desel();
			`CHK("status cleared", 1'b0, oe)
			host.sel();
			host.tick(8);
			`CHK("status stays off", 1'b0, oe)
			host.desel();
		end
	endtask

	// read nb bits from address a, dummy zero first
	task automatic rd(input int nb, input logic [31:0] e);
		sei_note_t n;
		n.m = 32'h1;
		n.v = 32'h0;
		q.push_back(n);
		n.m = (nb == 32) ? 32'hFFFFFFFF : (32'h1 << nb) - 32'h1;
		n.v = e;
		q.push_back(n);
		host.sel();
		host.xfer(wide ? 11 : 12, wide ? {21'h0, 1'b1, sei_pkg::OPC_READ, a[7:0]}
			: {20'h0, 1'b1, sei_pkg::OPC_READ, a}, 1);
		host.xfer(nb, 32'h0, 1);
		host.desel();
	endtask

	// watchdog
	initial
	begin
		repeat (60000) @(posedge mclk);
		err_total++;
		final_report();
	end

	// main sequence
	initial
	begin
		mclk = 1'b0;
		rst_b = 1'b0;
		wide = 1'b1;
		fast = 1'b0;
		seed = 32'h00010234; // seed 66100
		err_total = 0;
		checks_done = 0;
		bcnt = 0;
		blen = 0;
		repeat (8) @(negedge mclk);
		`CHK("enable after reset", 1'b0, en)
		rst_b = 1'b1;
		repeat (4) @(negedge mclk);
		`CHK("idle data-out", 1'b0, oe)
		seed = lfsr(seed);
		a = seed[8:0];
		d = seed[31:16];
		prog(27, {5'h0, 1'b1, sei_pkg::OPC_WRITE, a[7:0], d}, 0, 0);
		prog(11, sp(1'b1, sei_pkg::SUB_ENABLE), 0, 0);
		`CHK("enabled", 1'b1, en)
		host.sel();
		host.xfer(6, 32'h2D, 0);
		host.desel();
		`CHK("partial dropped", 1'b0, busy)
		prog(27, {5'h0, 1'b1, sei_pkg::OPC_WRITE, a[7:0], d}, P_WS, 1);
		seed = lfsr(seed);
		d2 = seed[31:16];
		prog(27, {5'h0, 1'b1, sei_pkg::OPC_WRITE, a[7:0] + 8'h1, d2}, P_WS, 0);
		rd(32, {d, d2});
		prog(11, {21'h0, 1'b1, sei_pkg::OPC_ERASE, a[7:0]}, P_WS, 0);
		rd(16, 32'h0000FFFF);
		wide = 1'b0;
		a = {a[7:0] + 8'h1, 1'b0};
		rd(16, {16'h0, d2});
		seed = lfsr(seed);
		a = seed[8:0];
		prog(20, {12'h0, 1'b1, sei_pkg::OPC_WRITE, a, d[7:0]}, P_WS, 0);
		rd(8, {24'h0, d[7:0]});
		prog(12, sp(1'b0, sei_pkg::SUB_DISABLE), 0, 0);
		`CHK("disabled", 1'b0, en)
		prog(12, sp(1'b0, sei_pkg::SUB_ER_ALL), 0, 0);
		rd(8, {24'h0, d[7:0]});
		prog(12, sp(1'b0, sei_pkg::SUB_ENABLE), 0, 0);
		`CHK("enabled again", 1'b1, en)
		wide = 1'b1;
		fast = 1'b1;
		seed = lfsr(seed);
		a = seed[8:0];
		d = seed[31:16];
		prog(27, {5'h0, 1'b1, sei_pkg::OPC_WRITE, a[7:0], d}, P_WF, 0);
		rd(16, {16'h0, d});
		fast = 1'b0;
		prog(11, sp(1'b1, sei_pkg::SUB_ER_ALL), P_EA, 1);
		rd(16, 32'h0000FFFF);
		seed = lfsr(seed);
		d = seed[31:16];
		prog(27, {5'h0, 1'b1, sei_pkg::OPC_SPECIAL, sei_pkg::SUB_WR_ALL, 6'h0, d}, P_WA, 0);
		a = 9'h0FF;
		rd(32, {d, d});
		prog(11, sp(1'b1, sei_pkg::SUB_DISABLE), 0, 0);
		`CHK("disabled at end", 1'b0, en)
		`CHK("notes left", 0, q.size())
		final_report();
	end
endmodule
